/* File: src/wd_counter.sv */
`timescale 1ns/1ps
module wd_counter (
    input  wire logic                    pclk,
    input  wire logic                    presetn,
    input  wire logic                    tick,
    input  wire logic                    clear,
    input  wire logic                    run,
    input  wire logic [4:0]              prescale,
    output logic [wd_pkg::CNT_W-1:0]     count,
    output logic                         expire
);
    typedef struct packed {
        logic [wd_pkg::CNT_W-1:0] count;
        logic                     expire;
    } cnt_state_type;

    cnt_state_type               s;
    cnt_state_type               next_s;
    logic [wd_pkg::CNT_W-1:0]    term;

    always_comb begin
        term          = wd_pkg::terminal_count(prescale);
        next_s        = s;
        next_s.expire = 1'b0;
        if (clear) begin
            next_s.count = '0;
        end else if (run && tick) begin
            if (s.count >= term) begin
                next_s.count  = '0;
                next_s.expire = 1'b1;
            end else begin
                next_s.count = s.count + 23'h000001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign count  = s.count;
    assign expire = s.expire;

    property p_expire_at_term;
        @(posedge pclk) disable iff (!presetn)
        expire |-> $past(s.count) >= $past(term) && $past(run) && $past(tick);
    endproperty
    a_expire_at_term: assert property (p_expire_at_term) else $error("expiry off terminal");
endmodule // wd_counter

/* File: src/wd_pkg.sv */
package wd_pkg;

    // apb map, byte addresses of aligned 32-bit words
    localparam int          APB_AW          = 8;
    localparam logic [7:0]  ADDR_CTRL0      = 8'h00;
    localparam logic [7:0]  ADDR_CORE_STAT  = 8'h04;
    localparam logic [7:0]  ADDR_PWR_CTRL   = 8'h08;
    localparam logic [7:0]  ADDR_INT_STAT   = 8'h0C;
    localparam logic [7:0]  ADDR_INT_MASK   = 8'h10;

    // watchdog_control_0 layout
    localparam int          CTRL_SEN_BIT    = 0;
    localparam int          CTRL_PS_LSB     = 1;
    localparam int          CTRL_PS_MSB     = 5;
    localparam logic        SEN_RESET       = 1'h0;
    localparam logic [4:0]  PS_DEFAULT      = 5'h0B;
    localparam logic [4:0]  PS_CFG_SOFT     = 5'h1F;
    localparam logic [4:0]  PS_MAX_CODE     = 5'h12;
    localparam int          PS_BASE_EXP     = 5;
    localparam int          CNT_W           = 23;

    // core status, power control and interrupt bit positions
    localparam int          CSTAT_PD_BIT    = 0;
    localparam int          CSTAT_TO_BIT    = 1;
    localparam int          PWR_WDRST_BIT   = 0;
    localparam int          EVT_WAKE_BIT    = 0;
    localparam int          EVT_RESET_BIT   = 1;
    localparam logic [1:0]  EVT_RESET_VAL   = 2'h0;
    localparam logic [1:0]  MASK_RESET_VAL  = 2'h0;

    // configuration modes of watchdog_mode_cfg
    localparam logic [1:0]  MODE_OFF        = 2'h0;
    localparam logic [1:0]  MODE_SOFT       = 2'h1;
    localparam logic [1:0]  MODE_NO_SLEEP   = 2'h2;
    localparam logic [1:0]  MODE_ON         = 2'h3;

    // slow oscillator tick derived from pclk
    localparam int          CLK_PERIOD_NS   = 10;
    localparam int          OSC_PERIOD_NS   = 32258;
    localparam int          TICK_CYCLES     = OSC_PERIOD_NS / CLK_PERIOD_NS;

    function automatic logic mode_active(input logic [1:0] mode,
                                         input logic       soft_wd_enable,
                                         input logic       asleep);
        unique case (mode)
            MODE_ON:       mode_active = 1'b1;
            MODE_NO_SLEEP: mode_active = !asleep;
            MODE_SOFT:     mode_active = soft_wd_enable;
            MODE_OFF:      mode_active = 1'b0;
        endcase
    endfunction

    // last count before expiry: 2^(n+5)-1 ticks, reserved codes act as 1:32
    function automatic logic [CNT_W-1:0] terminal_count(input logic [4:0] sel);
        logic [4:0] e;
        e = (sel > PS_MAX_CODE) ? 5'h00 : sel;
        terminal_count = CNT_W'((24'h000001 << (e + 5'(PS_BASE_EXP))) - 24'h000001);
    endfunction

endpackage

/* File: src/wd_tick_div.sv */
`timescale 1ns/1ps
module wd_tick_div #(
    parameter int DIV = wd_pkg::TICK_CYCLES
) (
    input  wire logic pclk,
    input  wire logic presetn,
    output logic      tick
);
    typedef struct packed {
        logic [15:0] cnt;
        logic        tick;
    } div_state_type;

    div_state_type s;
    div_state_type next_s;

    always_comb begin
        next_s = s;
        next_s.tick = 1'b0;
        if (s.cnt == 16'(DIV - 1)) begin
            next_s.cnt  = 16'h0000;
            next_s.tick = 1'b1;
        end else begin
            next_s.cnt = s.cnt + 16'h0001;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign tick = s.tick;
endmodule // wd_tick_div

/* File: src/wd_watchdog.sv */
`timescale 1ns/1ps
// Behaviour
// - The counter is cleared in the cycle after the device enters sleep.
// - With the mode keeping the watchdog on in sleep, counting resumes after that clear.
// - The counter is cleared again when the device leaves sleep.
// - While the oscillator start-up timer runs the counter is held at zero.
// - A time-out during sleep gives a wake request and no reset request.
// - A time-out during sleep sets the time-out flag and the power-down flag stays recorded.
// - Every watchdog time-out sets the reset-cause flag of the power control register.
// - The counter is held clear in mode 00, and in mode 01 while the software enable is 0.
// - In mode 10 the counter is cleared and stopped for the whole of sleep.
// - Leaving sleep clears the counter whatever the system clock source.
// - A change of the oscillator divider selection leaves the counter untouched.
// - Control register 0 holds zeros in bits 7-6, prescale in bits 5-1, enable in bit 0.
// - In mode 01 the watchdog runs only while the software enable is set.
// - Without a clear before expiry, a time-out while awake requests a reset.
// - Prescale loads 01011 when the configured value is 11111, else that value, read-only.
module wd_watchdog #(
    parameter int TICK_DIV = wd_pkg::TICK_CYCLES
) (
    input  wire logic                      pclk,
    input  wire logic                      presetn,
    input  wire logic                      psel,
    input  wire logic                      penable,
    input  wire logic                      pwrite,
    input  wire logic [wd_pkg::APB_AW-1:0] paddr,
    input  wire logic [31:0]               pwdata,
    output logic [31:0]                    prdata,
    output logic                           pready,
    output logic                           pslverr,
    input  wire logic [1:0]                watchdog_mode_cfg,
    input  wire logic [4:0]                cfg_prescale_sel,
    input  wire logic                      sleep_in,
    input  wire logic                      wd_clear_instr,
    input  wire logic                      osc_startup_timer,
    input  wire logic                      osc_fail,
    input  wire logic [3:0]                int_osc_divider_sel,
    output logic                           wd_reset_req,
    output logic                           wake_req,
    output logic                           timeout_flag,
    output logic                           powerdown_flag,
    output logic                           wd_reset_flag,
    output logic                           irq
);
    typedef struct packed {
        logic [4:0]  prescale;
        logic        soft_en;
        logic        loaded;
        logic        sleep_q;
        logic        tof;
        logic        pdf;
        logic        rstf;
        logic [1:0]  int_stat;
        logic [1:0]  int_mask;
        logic        irq;
        logic        wd_rst;
        logic        wake;
        logic [31:0] rdata;
        logic        rdy;
        logic        err;
    } state_type;

    state_type                   s;
    state_type                   next_s;
    logic                        tick;
    logic                        run;
    logic                        wd_clr;
    logic                        expire;
    logic [wd_pkg::CNT_W-1:0]    count;
    logic                        sleep_enter;
    logic                        sleep_exit;
    logic                        access;
    logic                        commit;
    logic                        wr;
    logic                        mapped;
    logic                        ps_writable;
    logic [1:0]                  evt_set;

    wd_tick_div #(
        .DIV     (TICK_DIV)
    ) u_div (
        .pclk    (pclk),
        .presetn (presetn),
        .tick    (tick)
    );

    wd_counter u_cnt (
        .pclk     (pclk),
        .presetn  (presetn),
        .tick     (tick),
        .clear    (wd_clr),
        .run      (run),
        .prescale (s.prescale),
        .count    (count),
        .expire   (expire)
    );

    always_comb begin
        sleep_enter = sleep_in && !s.sleep_q;
        sleep_exit  = !sleep_in && s.sleep_q;
        access      = psel && penable && !s.rdy;
        commit      = psel && penable && s.rdy;
        wr          = commit && pwrite && !s.err;
        mapped      = paddr == wd_pkg::ADDR_CTRL0 || paddr == wd_pkg::ADDR_CORE_STAT ||
                      paddr == wd_pkg::ADDR_PWR_CTRL || paddr == wd_pkg::ADDR_INT_STAT ||
                      paddr == wd_pkg::ADDR_INT_MASK;
        ps_writable = cfg_prescale_sel == wd_pkg::PS_CFG_SOFT;
        // mode 10 drops out while asleep, mode 01 follows the enable
        run = wd_pkg::mode_active(watchdog_mode_cfg, s.soft_en, sleep_in);
        // the divider selection is deliberately absent from the clear terms
        wd_clr = !run || sleep_enter || sleep_exit || osc_startup_timer
                 || wd_clear_instr || osc_fail
                 || (wr && paddr == wd_pkg::ADDR_CTRL0);
        evt_set = '0;
        evt_set[wd_pkg::EVT_WAKE_BIT]  = expire && sleep_in;
        evt_set[wd_pkg::EVT_RESET_BIT] = expire && !sleep_in;

        next_s         = s;
        next_s.sleep_q = sleep_in;
        next_s.rdy     = access;
        next_s.wd_rst  = expire && !sleep_in;
        next_s.wake    = expire && sleep_in;
        // strap caught once, on the first edge after release
        if (!s.loaded) begin
            next_s.loaded   = 1'b1;
            next_s.prescale = ps_writable ? wd_pkg::PS_DEFAULT : cfg_prescale_sel;
        end

        if (access) begin
            next_s.err   = !mapped;
            next_s.rdata = '0;
            if (!pwrite) begin
                unique case (paddr)
                    wd_pkg::ADDR_CTRL0: begin
                        next_s.rdata[wd_pkg::CTRL_PS_MSB:wd_pkg::CTRL_PS_LSB] = s.prescale;
                        next_s.rdata[wd_pkg::CTRL_SEN_BIT] = s.soft_en;
                    end
                    wd_pkg::ADDR_CORE_STAT: begin
                        next_s.rdata[wd_pkg::CSTAT_TO_BIT] = s.tof;
                        next_s.rdata[wd_pkg::CSTAT_PD_BIT] = s.pdf;
                    end
                    wd_pkg::ADDR_PWR_CTRL: next_s.rdata[wd_pkg::PWR_WDRST_BIT] = s.rstf;
                    wd_pkg::ADDR_INT_STAT: next_s.rdata[1:0] = s.int_stat;
                    wd_pkg::ADDR_INT_MASK: next_s.rdata[1:0] = s.int_mask;
                    default:               next_s.rdata = '0;
                endcase
            end
        end else if (!psel) begin
            next_s.err   = 1'b0;
            next_s.rdata = '0;
        end

        if (wr && paddr == wd_pkg::ADDR_CTRL0) begin
            next_s.soft_en = pwdata[wd_pkg::CTRL_SEN_BIT];
            if (ps_writable && s.loaded) begin
                next_s.prescale = pwdata[wd_pkg::CTRL_PS_MSB:wd_pkg::CTRL_PS_LSB];
            end
        end
        if (wr && paddr == wd_pkg::ADDR_INT_MASK) begin
            next_s.int_mask = pwdata[1:0];
        end

        // hardware sets win over clears in the same cycle
        if (wd_clear_instr) begin
            next_s.tof = 1'b0;
            next_s.pdf = 1'b0;
        end
        if (sleep_enter) begin
            next_s.pdf = 1'b1;
        end
        if (expire) begin
            next_s.tof = 1'b1;
        end
        if (wr && paddr == wd_pkg::ADDR_PWR_CTRL && pwdata[wd_pkg::PWR_WDRST_BIT]) begin
            next_s.rstf = 1'b0;
        end
        if (expire) begin
            next_s.rstf = 1'b1;
        end
        if (wr && paddr == wd_pkg::ADDR_INT_STAT) begin
            next_s.int_stat = s.int_stat & ~pwdata[1:0];
        end
        next_s.int_stat = next_s.int_stat | evt_set;
        next_s.irq      = |(next_s.int_stat & next_s.int_mask);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s          <= '0;
            s.prescale <= wd_pkg::PS_DEFAULT;
            s.soft_en  <= wd_pkg::SEN_RESET;
            s.int_stat <= wd_pkg::EVT_RESET_VAL;
            s.int_mask <= wd_pkg::MASK_RESET_VAL;
        end else begin
            s <= next_s;
        end
    end

    assign prdata         = s.rdata;
    assign pready         = s.rdy;
    assign pslverr        = s.err;
    assign wd_reset_req   = s.wd_rst;
    assign wake_req       = s.wake;
    assign timeout_flag   = s.tof;
    assign powerdown_flag = s.pdf;
    assign wd_reset_flag  = s.rstf;
    assign irq            = s.irq;

    // checks
    property p_sleep_entry_clear;
        @(posedge pclk) disable iff (!presetn)
        $rose(sleep_in) |=> count == '0;
    endproperty
    a_sleep_entry_clear: assert property (p_sleep_entry_clear) else $error("no clear on sleep");

    property p_resume_in_sleep;
        @(posedge pclk) disable iff (!presetn)
        sleep_in && s.sleep_q && watchdog_mode_cfg == wd_pkg::MODE_ON && tick && !wd_clr
        && !expire && count < wd_pkg::terminal_count(s.prescale)
        |=> count == $past(count) + 23'h000001;
    endproperty
    a_resume_in_sleep: assert property (p_resume_in_sleep) else $error("no count in sleep");

    property p_sleep_exit_clear;
        @(posedge pclk) disable iff (!presetn)
        $fell(sleep_in) |=> count == '0;
    endproperty
    a_sleep_exit_clear: assert property (p_sleep_exit_clear) else $error("no clear on exit");

    property p_ost_hold;
        @(posedge pclk) disable iff (!presetn)
        osc_startup_timer [*2] |=> count == '0 && !expire;
    endproperty
    a_ost_hold: assert property (p_ost_hold) else $error("count moved during start-up");

    property p_sleep_wake;
        @(posedge pclk) disable iff (!presetn)
        expire && sleep_in |=> wake_req && !wd_reset_req ##1 !wake_req;
    endproperty
    a_sleep_wake: assert property (p_sleep_wake) else $error("sleep timeout not a wake");

    property p_flags_on_wake;
        @(posedge pclk) disable iff (!presetn)
        expire && sleep_in |=> timeout_flag && wd_reset_flag;
    endproperty
    a_flags_on_wake: assert property (p_flags_on_wake) else $error("wake flags missing");

    property p_mode_off_hold;
        @(posedge pclk) disable iff (!presetn)
        (watchdog_mode_cfg == wd_pkg::MODE_OFF
         || (watchdog_mode_cfg == wd_pkg::MODE_SOFT && !s.soft_en)) |=> count == '0;
    endproperty
    a_mode_off_hold: assert property (p_mode_off_hold) else $error("count in disabled mode");

    property p_nosleep_stopped;
        @(posedge pclk) disable iff (!presetn)
        watchdog_mode_cfg == wd_pkg::MODE_NO_SLEEP && sleep_in |=> count == '0 && !expire;
    endproperty
    a_nosleep_stopped: assert property (p_nosleep_stopped) else $error("mode 10 ran asleep");

    property p_divider_change;
        @(posedge pclk) disable iff (!presetn)
        $changed(int_osc_divider_sel) && !wd_clr && count < wd_pkg::terminal_count(s.prescale)
        |=> count == $past(count) + 23'($past(tick && run));
    endproperty
    a_divider_change: assert property (p_divider_change) else $error("divider change hit count");

    property p_ctrl_read;
        @(posedge pclk) disable iff (!presetn)
        access && !pwrite && paddr == wd_pkg::ADDR_CTRL0
        |=> pready && prdata == {26'h0000000, s.prescale, s.soft_en};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read) else $error("control read layout");

    property p_awake_reset;
        @(posedge pclk) disable iff (!presetn)
        expire && !sleep_in |=> wd_reset_req && !wake_req ##1 !wd_reset_req;
    endproperty
    a_awake_reset: assert property (p_awake_reset) else $error("awake timeout no reset");

    property p_strap_load;
        @(posedge pclk) disable iff (!presetn)
        $rose(s.loaded) |-> s.prescale == (($past(cfg_prescale_sel) == wd_pkg::PS_CFG_SOFT)
                                           ? wd_pkg::PS_DEFAULT : $past(cfg_prescale_sel));
    endproperty
    a_strap_load: assert property (p_strap_load) else $error("prescale strap load");

    property p_osc_fail_clear;
        @(posedge pclk) disable iff (!presetn)
        osc_fail |=> count == '0;
    endproperty
    a_osc_fail_clear: assert property (p_osc_fail_clear) else $error("osc fail no clear");

    property p_pdf_on_sleep;
        @(posedge pclk) disable iff (!presetn)
        sleep_enter |=> powerdown_flag;
    endproperty
    a_pdf_on_sleep: assert property (p_pdf_on_sleep) else $error("no power-down flag");

    property p_awake_flags;
        @(posedge pclk) disable iff (!presetn)
        expire && !sleep_in |=> timeout_flag && wd_reset_flag;
    endproperty
    a_awake_flags: assert property (p_awake_flags) else $error("awake flags missing");

    property p_wake_event;
        @(posedge pclk) disable iff (!presetn)
        expire && sleep_in |=> s.int_stat[wd_pkg::EVT_WAKE_BIT];
    endproperty
    a_wake_event: assert property (p_wake_event) else $error("wake event not recorded");

    property p_clear_instr;
        @(posedge pclk) disable iff (!presetn)
        wd_clear_instr |=> count == '0;
    endproperty
    a_clear_instr: assert property (p_clear_instr) else $error("clear instr ignored");

    property p_ps_readonly;
        @(posedge pclk) disable iff (!presetn)
        wr && paddr == wd_pkg::ADDR_CTRL0 && !ps_writable && s.loaded |=> $stable(s.prescale);
    endproperty
    a_ps_readonly: assert property (p_ps_readonly) else $error("read-only prescale moved");

    property p_sen_reset;
        @(posedge pclk) disable iff (!presetn)
        $rose(s.loaded) |-> !s.soft_en;
    endproperty
    a_sen_reset: assert property (p_sen_reset) else $error("enable not clear after reset");

    property p_soft_runs;
        @(posedge pclk) disable iff (!presetn)
        watchdog_mode_cfg == wd_pkg::MODE_SOFT && s.soft_en && tick && !wd_clr
        && count < wd_pkg::terminal_count(s.prescale) |=> count == $past(count) + 23'h000001;
    endproperty
    a_soft_runs: assert property (p_soft_runs) else $error("no count when enabled");

    c_wake:  cover property (@(posedge pclk) disable iff (!presetn) $rose(wake_req));
    c_reset: cover property (@(posedge pclk) disable iff (!presetn) $rose(wd_reset_req));
    c_irq:   cover property (@(posedge pclk) disable iff (!presetn) $rose(irq));
    c_wr:    cover property (@(posedge pclk) disable iff (!presetn)
                             wr && paddr == wd_pkg::ADDR_CTRL0);
endmodule // wd_watchdog

/* File: test/tb_windowed_watchdog_sleep_prescale.sv */
`timescale 1ns/1ps
module tb_windowed_watchdog_sleep_prescale;
    logic        pclk = 1'b0;
    logic        presetn = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [7:0]  paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [1:0]  watchdog_mode_cfg = 2'h0;
    logic [4:0]  cfg_prescale_sel = 5'h1F;
    logic        sleep_in = 1'b0;
    logic        wd_clear_instr = 1'b0;
    logic        osc_startup_timer = 1'b0;
    logic        osc_fail = 1'b0;
    logic [3:0]  int_osc_divider_sel = 4'h0;
    logic        wd_reset_req;
    logic        wake_req;
    logic        timeout_flag;
    logic        powerdown_flag;
    logic        wd_reset_flag;
    logic        irq;
    int          mismatches = 0;
    int          tests_run = 0;

    // short tick so a 1:32 expiry is 128 pclk cycles
    wd_watchdog #(.TICK_DIV(4)) uut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .watchdog_mode_cfg(watchdog_mode_cfg), .cfg_prescale_sel(cfg_prescale_sel),
        .sleep_in(sleep_in), .wd_clear_instr(wd_clear_instr),
        .osc_startup_timer(osc_startup_timer), .osc_fail(osc_fail),
        .int_osc_divider_sel(int_osc_divider_sel), .wd_reset_req(wd_reset_req),
        .wake_req(wake_req), .timeout_flag(timeout_flag), .powerdown_flag(powerdown_flag),
        .wd_reset_flag(wd_reset_flag), .irq(irq));

    always #5 pclk = ~pclk;

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, mismatches);
        if (mismatches == 0 && tests_run > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d,
                       output logic [31:0] rd, output logic err);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            mismatches++;
            $display("Error at %0t: pready timeout got %h expected %h", $time, pready, 1'b1);
            finish_test();
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] rd;
        logic        err;
        apb(1'b1, a, d, rd, err);
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        logic [31:0] rd;
        logic        err;
        apb(1'b0, a, 32'h0, rd, err);
        check(rd, exp);
        check({31'h0, err}, 32'h0);
    endtask

    // bounded wait; n == bound means no request was seen
    task automatic wait_event(input int bound, output int n);
        n = 0;
        while (wd_reset_req !== 1'b1 && wake_req !== 1'b1 && n < bound) begin
            @(posedge pclk);
            #1;
            n++;
        end
    endtask

    task automatic expect_event(input int exp, input logic want_wake);
        int n;
        wait_event(exp + 40, n);
        check(32'(n > exp - 10 && n < exp + 10), 32'h1);
        check({31'h0, wake_req}, {31'h0, want_wake});
        check({31'h0, wd_reset_req}, {31'h0, !want_wake});
    endtask

    task automatic set_mode(input logic [1:0] m, input logic s);
        @(posedge pclk);
        watchdog_mode_cfg <= m;
        sleep_in <= s;
    endtask

    task automatic t_reset_values;
        logic [31:0] rd;
        logic        err;
        rd_chk(wd_pkg::ADDR_CTRL0, 32'h16);
        rd_chk(wd_pkg::ADDR_INT_MASK, 32'h0);
        rd_chk(wd_pkg::ADDR_PWR_CTRL, 32'h0);
        apb(1'b0, 8'h20, 32'h0, rd, err);
        check({31'h0, err}, 32'h1);
        check(rd, 32'h0);
    endtask

    task automatic t_awake_timeout;
        set_mode(wd_pkg::MODE_SOFT, 1'b0);
        wr(wd_pkg::ADDR_CTRL0, 32'h01);
        expect_event(128, 1'b0);
        check({31'h0, wd_reset_flag}, 32'h1);
        set_mode(wd_pkg::MODE_OFF, 1'b0);
        rd_chk(wd_pkg::ADDR_CORE_STAT, 32'h2);
        rd_chk(wd_pkg::ADDR_PWR_CTRL, 32'h1);
        wr(wd_pkg::ADDR_PWR_CTRL, 32'h1);
        rd_chk(wd_pkg::ADDR_PWR_CTRL, 32'h0);
        check({31'h0, wd_reset_flag}, 32'h0);
        rd_chk(wd_pkg::ADDR_INT_STAT, 32'h2);
        check({31'h0, irq}, 32'h0);
        wr(wd_pkg::ADDR_INT_MASK, 32'h3);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h1);
        wr(wd_pkg::ADDR_INT_STAT, 32'h3);
        repeat (2) @(posedge pclk);
        check({31'h0, irq}, 32'h0);
        rd_chk(wd_pkg::ADDR_INT_STAT, 32'h0);
    endtask

    task automatic t_prescale;
        set_mode(wd_pkg::MODE_ON, 1'b0);
        wr(wd_pkg::ADDR_CTRL0, 32'h03);
        expect_event(256, 1'b0);
        wr(wd_pkg::ADDR_CTRL0, 32'h27);
        expect_event(128, 1'b0);
        set_mode(wd_pkg::MODE_OFF, 1'b0);
    endtask

    task automatic t_disabled;
        int n;
        set_mode(wd_pkg::MODE_OFF, 1'b0);
        wr(wd_pkg::ADDR_CTRL0, 32'h01);
        wait_event(300, n);
        check(n, 300);
        set_mode(wd_pkg::MODE_SOFT, 1'b0);
        wr(wd_pkg::ADDR_CTRL0, 32'h00);
        wait_event(300, n);
        check(n, 300);
        set_mode(wd_pkg::MODE_NO_SLEEP, 1'b1);
        wr(wd_pkg::ADDR_CTRL0, 32'h01);
        wait_event(300, n);
        check(n, 300);
        set_mode(wd_pkg::MODE_OFF, 1'b0);
    endtask

    task automatic t_sleep;
        int n;
        set_mode(wd_pkg::MODE_ON, 1'b0);
        // start from clear flags so sleep entry and the wake have to set them
        @(posedge pclk);
        wd_clear_instr <= 1'b1;
        @(posedge pclk);
        wd_clear_instr <= 1'b0;
        wr(wd_pkg::ADDR_INT_STAT, 32'h3);
        wr(wd_pkg::ADDR_CTRL0, 32'h01);
        wait_event(100, n);
        set_mode(wd_pkg::MODE_ON, 1'b1);
        expect_event(128, 1'b1);
        check({30'h0, timeout_flag, powerdown_flag}, 32'h3);
        rd_chk(wd_pkg::ADDR_INT_STAT, 32'h1);
        wr(wd_pkg::ADDR_INT_STAT, 32'h3);
        wait_event(60, n);
        set_mode(wd_pkg::MODE_ON, 1'b0);
        expect_event(128, 1'b0);
        set_mode(wd_pkg::MODE_OFF, 1'b0);
        @(posedge pclk);
        wd_clear_instr <= 1'b1;
        @(posedge pclk);
        wd_clear_instr <= 1'b0;
        repeat (2) @(posedge pclk);
        check({30'h0, timeout_flag, powerdown_flag}, 32'h0);
    endtask

    task automatic t_clear_sources;
        int n;
        set_mode(wd_pkg::MODE_ON, 1'b0);
        wr(wd_pkg::ADDR_CTRL0, 32'h01);
        for (int k = 0; k < 2; k++) begin
            repeat (4) begin
                wait_event(90, n);
                check(n, 90);
                @(posedge pclk);
                if (k == 0) wd_clear_instr <= 1'b1;
                else osc_fail <= 1'b1;
                @(posedge pclk);
                wd_clear_instr <= 1'b0;
                osc_fail <= 1'b0;
            end
        end
        @(posedge pclk);
        osc_startup_timer <= 1'b1;
        wait_event(300, n);
        check(n, 300);
        @(posedge pclk);
        osc_startup_timer <= 1'b0;
        wr(wd_pkg::ADDR_CTRL0, 32'h01);
        wait_event(40, n);
        @(posedge pclk);
        int_osc_divider_sel <= 4'h7;
        expect_event(87, 1'b0);
        set_mode(wd_pkg::MODE_OFF, 1'b0);
    endtask

    // a fixed strap makes the prescale field read-only, enable stays writable
    task automatic t_strap;
        @(posedge pclk);
        presetn <= 1'b0;
        cfg_prescale_sel <= 5'h05;
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        rd_chk(wd_pkg::ADDR_CTRL0, 32'h0A);
        wr(wd_pkg::ADDR_CTRL0, 32'h3F);
        rd_chk(wd_pkg::ADDR_CTRL0, 32'h0B);
    endtask

    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        repeat (2) @(posedge pclk);
        t_reset_values();
        t_awake_timeout();
        t_prescale();
        t_disabled();
        t_sleep();
        t_clear_sources();
        t_strap();
        finish_test();
    end
endmodule // tb_windowed_watchdog_sleep_prescale
